// ==== rtl/tcch_frame_mem.sv ====
/*
  Frame buffer: byte-writable word memory with a registered read port.
  Assumes the caller keeps waddr and raddr below DEPTH.
*/
`timescale 1ns/1ps
`default_nettype none
module tcch_frame_mem #(
  parameter int DW    = 32,
  parameter int DEPTH = 9,
  parameter int AW    = 4
) (
  // clock
  input  wire logic          aclk,
  // write port
  input  wire logic [DW/8-1:0] we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // read port
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_q
);
  logic [DW-1:0] mem_q [0:DEPTH-1];

  always_ff @(posedge aclk) begin
    for (int i = 0; i < DW/8; i++) begin
      if (we[i]) begin
        mem_q[waddr][8*i +: 8] <= wdata[8*i +: 8];
      end
    end
    rdata_q <= mem_q[raddr];
  end
endmodule : tcch_frame_mem
`default_nettype wire

// ==== rtl/tcch_pkg.sv ====
/*
  Shared constants and types of the tag configuration command handler:
  register map, status codes, option codes and lengths, setting reset values.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tcch_pkg;
  // register map, byte addresses on the AXI4-Lite port
  localparam int          ADDR_W      = 12;
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_SET0   = 12'h008;
  localparam logic [11:0] ADDR_SET1   = 12'h00C;
  localparam logic [11:0] ADDR_RESP0  = 12'h010;
  localparam logic [11:0] ADDR_BUF    = 12'h040;
  localparam int          BUF_WORDS   = 9;
  localparam int          FRAME_BYTES = 36;

  // register select codes
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_CTRL = 4'h1;
  localparam logic [3:0] SEL_STAT = 4'h2;
  localparam logic [3:0] SEL_SET0 = 4'h3;
  localparam logic [3:0] SEL_SET1 = 4'h4;
  localparam logic [3:0] SEL_RESP = 4'h5;
  localparam logic [3:0] SEL_BUF  = 4'h6;

  // field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_LEN_LSB   = 8;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_DONE_BIT  = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // frame codes and status
  localparam logic [7:0] CMD_ADDL_FRAME = 8'hAF;
  localparam logic [7:0] CMD_CONFIG_SET = 8'h5C;
  localparam logic [7:0] SW1_OK         = 8'h91;
  localparam logic [7:0] ST_OK          = 8'h00;
  localparam logic [7:0] ST_LENGTH      = 8'h7E;
  localparam logic [7:0] ST_AUTH        = 8'hAE;
  localparam logic [7:0] ST_MEMORY      = 8'hEE;
  localparam logic [7:0] ST_PARAM       = 8'h9E;
  localparam logic [5:0] AUTH2_LEN      = 6'h21;
  localparam logic [4:0] PROOF_BYTES    = 5'h10;

  // options and data lengths
  localparam logic [7:0] OPT_TAG  = 8'h00;
  localparam logic [7:0] OPT_SM   = 8'h04;
  localparam logic [7:0] OPT_CAP  = 8'h05;
  localparam logic [7:0] OPT_FAIL = 8'h0A;
  localparam logic [7:0] OPT_HW   = 8'h0B;
  localparam logic [3:0] LEN_TAG  = 4'h1;
  localparam logic [3:0] LEN_SM   = 4'h2;
  localparam logic [3:0] LEN_CAP  = 4'hA;
  localparam logic [3:0] LEN_FAIL = 4'h5;
  localparam logic [3:0] LEN_HW   = 4'h1;
  localparam logic [7:0] TAGCFG_RSVD_MASK = 8'hFD;

  typedef struct packed {
    logic [15:0] fail_count_decrement;
    logic [15:0] fail_count_limit;
    logic [7:0]  cap6;
    logic [7:0]  cap5;
    logic        hw_strong;
    logic        fail_counter_enable;
    logic        leakage_resilient_mode;
    logic        chain_write_block;
    logic        random_identity_select;
  } tcch_settings_t;

  localparam tcch_settings_t SETTINGS_RST = '{
    fail_count_decrement: 16'h000A,
    fail_count_limit:     16'h03E8,
    cap6: 8'h00, cap5: 8'h00, hw_strong: 1'b1, fail_counter_enable: 1'b1,
    leakage_resilient_mode: 1'b0, chain_write_block: 1'b0,
    random_identity_select: 1'b0};
endpackage : tcch_pkg

// ==== rtl/tcch_top.sv ====
/*
  Tag configuration command handler: second exchange of the repeat
  resilient authentication and the configuration set command, behind an
  AXI4-Lite slave. Assumes the frame layer writes a plaintext frame into
  the buffer, a crypto engine checks the reader proof, and a non-volatile
  store commits settings; all on aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module tcch_top (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // axi4-lite slave
  input  wire logic [11:0]  s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [11:0]  s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  // authentication state
  input  wire logic         auth_amk_active,
  input  wire logic         comm_full_active,
  // crypto engine
  output logic              mac_req,
  output logic [127:0]      mac_reader_nonce,
  output logic [127:0]      mac_reader_proof,
  input  wire logic         mac_ack,
  input  wire logic         mac_ok,
  input  wire logic         mac_err,
  input  wire logic [127:0] mac_tag_proof,
  // non-volatile store
  output logic              nv_req,
  output tcch_pkg::tcch_settings_t nv_wdata,
  input  wire logic         nv_ack,
  input  wire logic         nv_err,
  // settings and events
  output tcch_pkg::tcch_settings_t settings,
  output logic              cmd_done
);
  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_LOAD  = 6'h02,
    S_CHECK = 6'h04,
    S_MAC   = 6'h08,
    S_NVW   = 6'h10,
    S_DONE  = 6'h20
  } tcch_state_t;

  function automatic logic [3:0] reg_sel(input logic [11:0] a);
    if (a == tcch_pkg::ADDR_CTRL)        return tcch_pkg::SEL_CTRL;
    else if (a == tcch_pkg::ADDR_STATUS) return tcch_pkg::SEL_STAT;
    else if (a == tcch_pkg::ADDR_SET0)   return tcch_pkg::SEL_SET0;
    else if (a == tcch_pkg::ADDR_SET1)   return tcch_pkg::SEL_SET1;
    else if (a[11:4] == tcch_pkg::ADDR_RESP0[11:4] && a[1:0] == 2'h0) return tcch_pkg::SEL_RESP;
    else if (a[11:6] == tcch_pkg::ADDR_BUF[11:6] && a[1:0] == 2'h0
             && a[5:2] < 4'(tcch_pkg::BUF_WORDS)) return tcch_pkg::SEL_BUF;
    else return tcch_pkg::SEL_NONE;
  endfunction : reg_sel

  // expected data length per option, zero for reserved options
  function automatic logic [3:0] opt_len(input logic [7:0] o);
    case (o)
      tcch_pkg::OPT_TAG:  return tcch_pkg::LEN_TAG;
      tcch_pkg::OPT_SM:   return tcch_pkg::LEN_SM;
      tcch_pkg::OPT_CAP:  return tcch_pkg::LEN_CAP;
      tcch_pkg::OPT_FAIL: return tcch_pkg::LEN_FAIL;
      tcch_pkg::OPT_HW:   return tcch_pkg::LEN_HW;
      default:            return 4'h0;
    endcase
  endfunction : opt_len

  tcch_state_t              state_q;
  logic [11:0]              awaddr_q;
  logic [31:0]              wdata_q;
  logic [3:0]               wstrb_q;
  logic                     aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [1:0]               bresp_q, rresp_q;
  logic [31:0]              rdata_q;
  logic [5:0]               len_q;
  logic                     done_q;
  logic [7:0]               sw2_q;
  logic [4:0]               resp_len_q;
  logic [127:0]             resp_q;
  logic [3:0]               ld_cnt_q;
  logic [8*tcch_pkg::FRAME_BYTES-1:0] frame_q;
  tcch_pkg::tcch_settings_t settings_q;
  tcch_pkg::tcch_settings_t new_q;
  tcch_pkg::tcch_settings_t new_d;
  logic                     cmd_done_q;
  logic [31:0]              mem_rdata;
  logic [7:0]               opt_data [0:9];

  // bus side: a write lands one cycle after both halves are taken
  wire logic [3:0]  wsel     = reg_sel(awaddr_q);
  wire logic [3:0]  rsel     = reg_sel(s_axi_araddr);
  wire logic        do_write = aw_have_q && w_have_q && !bvalid_q;
  wire logic        do_read  = s_axi_arvalid && !rvalid_q;
  wire logic        busy     = state_q != S_IDLE;
  wire logic        start    = do_write && wsel == tcch_pkg::SEL_CTRL && wstrb_q[0]
                               && wdata_q[tcch_pkg::CTRL_START_BIT] && !busy;
  wire logic [31:0] stat_word = {3'b000, resp_len_q, sw2_q, tcch_pkg::SW1_OK, 6'h00,
                                 done_q, busy};
  wire logic [31:0] resp_word = resp_q[{s_axi_araddr[3:2], 5'b00000} +: 32];
  // the frame buffer is write-only from the bus; reads of it return zero
  wire logic [31:0] rd_word =
    (rsel == tcch_pkg::SEL_CTRL) ? {18'h0_0000, len_q, 8'h00} :
    (rsel == tcch_pkg::SEL_STAT) ? stat_word :
    (rsel == tcch_pkg::SEL_SET0) ? settings_q[52:21] :
    (rsel == tcch_pkg::SEL_SET1) ? {11'h000, settings_q[20:0]} :
    (rsel == tcch_pkg::SEL_RESP) ? resp_word : 32'h0000_0000;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // frame fields: command byte, option byte, then the data bytes
  wire logic [7:0] f_cmd = frame_q[7:0];
  wire logic [7:0] f_opt = frame_q[15:8];
  for (genvar k = 0; k < 10; k++) begin : g_data
    assign opt_data[k] = frame_q[16 + 8*k +: 8];
  end

  // configuration checks, in the order the status codes take precedence
  wire logic [5:0] dlen     = len_q - 6'h02;
  wire logic [3:0] exp_len  = opt_len(f_opt);
  wire logic       opt_rsvd = exp_len == 4'h0;
  wire logic       auth_ok  = auth_amk_active && comm_full_active;
  wire logic       len_bad  = dlen != {2'b00, exp_len};
  wire logic       tag_bad  = f_opt == tcch_pkg::OPT_TAG
                              && (opt_data[0] & tcch_pkg::TAGCFG_RSVD_MASK) != 8'h00;
  wire logic       lim_bad  = f_opt == tcch_pkg::OPT_FAIL && opt_data[0][0]
                              && {opt_data[2], opt_data[1]} == 16'h0000;
  wire logic [7:0] cfg_status = opt_rsvd ? tcch_pkg::ST_PARAM :
                                !auth_ok ? tcch_pkg::ST_AUTH :
                                len_bad  ? tcch_pkg::ST_LENGTH :
                                (tag_bad || lim_bad) ? tcch_pkg::ST_PARAM : tcch_pkg::ST_OK;

  // new settings start from the stored copy; zero tag, sm and resilient bits mean no change
  always_comb begin
    new_d = settings_q;
    case (f_opt)
      tcch_pkg::OPT_TAG: begin
        new_d.random_identity_select = settings_q.random_identity_select | opt_data[0][1];
      end
      tcch_pkg::OPT_SM: begin
        new_d.chain_write_block = settings_q.chain_write_block | opt_data[0][2];
      end
      tcch_pkg::OPT_CAP: begin
        // resilient mode is one-way: no encoding clears it
        new_d.leakage_resilient_mode = settings_q.leakage_resilient_mode | opt_data[4][1];
        new_d.cap5 = opt_data[8];
        new_d.cap6 = opt_data[9];
      end
      tcch_pkg::OPT_FAIL: begin
        new_d.fail_counter_enable = opt_data[0][0];
        if (opt_data[0][0]) begin
          new_d.fail_count_limit     = {opt_data[2], opt_data[1]};
          new_d.fail_count_decrement = {opt_data[4], opt_data[3]};
        end
      end
      tcch_pkg::OPT_HW: begin
        new_d.hw_strong = opt_data[0][0];
      end
      default: begin
        new_d = settings_q;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      rvalid_q  <= 1'b0;
      bresp_q   <= tcch_pkg::RESP_OKAY;
      rresp_q   <= tcch_pkg::RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q  <= s_axi_awaddr;
        aw_have_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        w_have_q <= 1'b1;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (wsel == tcch_pkg::SEL_NONE) ? tcch_pkg::RESP_SLVERR : tcch_pkg::RESP_OKAY;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (do_read) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_word;
        rresp_q  <= (rsel == tcch_pkg::SEL_NONE) ? tcch_pkg::RESP_SLVERR : tcch_pkg::RESP_OKAY;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // frame loader: registered read port, so each word lands one cycle late
  wire logic [3:0] ld_prev = ld_cnt_q - 4'h1;
  wire logic [3:0] ld_addr = (ld_cnt_q < 4'(tcch_pkg::BUF_WORDS)) ? ld_cnt_q : 4'h0;
  wire logic [3:0] mem_we  = (do_write && wsel == tcch_pkg::SEL_BUF) ? wstrb_q : 4'h0;

  tcch_frame_mem #(
    .DW    (32),
    .DEPTH (tcch_pkg::BUF_WORDS),
    .AW    (4)
  ) i_frame_mem (
    .aclk    (aclk),
    .we      (mem_we),
    .waddr   (awaddr_q[5:2]),
    .wdata   (wdata_q),
    .raddr   (ld_addr),
    .rdata_q (mem_rdata)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= S_IDLE;
      len_q      <= 6'h00;
      ld_cnt_q   <= 4'h0;
      frame_q    <= '0;
      done_q     <= 1'b0;
      cmd_done_q <= 1'b0;
      sw2_q      <= tcch_pkg::ST_OK;
      resp_len_q <= 5'h00;
      resp_q     <= '0;
      new_q      <= tcch_pkg::SETTINGS_RST;
      settings_q <= tcch_pkg::SETTINGS_RST;
    end else begin
      cmd_done_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (start) begin
            len_q      <= wdata_q[tcch_pkg::CTRL_LEN_LSB +: 6];
            ld_cnt_q   <= 4'h0;
            done_q     <= 1'b0;
            resp_len_q <= 5'h00;
            state_q    <= S_LOAD;
          end
        end
        S_LOAD: begin
          ld_cnt_q <= ld_cnt_q + 4'h1;
          if (ld_cnt_q != 4'h0) begin
            frame_q[{ld_prev, 5'b00000} +: 32] <= mem_rdata;
          end
          if (ld_cnt_q == 4'(tcch_pkg::BUF_WORDS)) begin
            state_q <= S_CHECK;
          end
        end
        S_CHECK: begin
          if (f_cmd == tcch_pkg::CMD_ADDL_FRAME) begin
            if (len_q != tcch_pkg::AUTH2_LEN) begin
              sw2_q   <= tcch_pkg::ST_LENGTH;
              state_q <= S_DONE;
            end else begin
              state_q <= S_MAC;
            end
          end else if (f_cmd == tcch_pkg::CMD_CONFIG_SET && cfg_status == tcch_pkg::ST_OK) begin
            new_q   <= new_d;
            state_q <= S_NVW;
          end else begin
            sw2_q   <= (f_cmd == tcch_pkg::CMD_CONFIG_SET) ? cfg_status : tcch_pkg::ST_PARAM;
            state_q <= S_DONE;
          end
        end
        S_MAC: begin
          if (mac_ack) begin
            state_q <= S_DONE;
            if (mac_err) begin
              sw2_q <= tcch_pkg::ST_MEMORY;
            end else if (mac_ok) begin
              sw2_q      <= tcch_pkg::ST_OK;
              resp_q     <= mac_tag_proof;
              resp_len_q <= tcch_pkg::PROOF_BYTES;
            end else begin
              sw2_q <= tcch_pkg::ST_AUTH;
            end
          end
        end
        S_NVW: begin
          if (nv_ack) begin
            state_q <= S_DONE;
            if (nv_err) begin
              sw2_q <= tcch_pkg::ST_MEMORY;
            end else begin
              // settings move only once the store has taken them
              sw2_q      <= tcch_pkg::ST_OK;
              settings_q <= new_q;
            end
          end
        end
        S_DONE: begin
          done_q     <= 1'b1;
          cmd_done_q <= 1'b1;
          state_q    <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  assign mac_req          = state_q == S_MAC;
  assign mac_reader_nonce = frame_q[8 +: 128];
  assign mac_reader_proof = frame_q[136 +: 128];
  assign nv_req           = state_q == S_NVW;
  assign nv_wdata         = new_q;
  assign settings         = settings_q;
  assign cmd_done         = cmd_done_q;

  mac_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mac_req |-> len_q == tcch_pkg::AUTH2_LEN)
    else $error("proof check started on a wrong-size frame");
  mac_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mac_req && !mac_ack |=> mac_req)
    else $error("proof request dropped before its answer");
  nv_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    nv_req |-> auth_amk_active && comm_full_active)
    else $error("settings store requested without authentication");
  commit_first_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(settings_q) |-> $past(nv_ack && !nv_err))
    else $error("settings changed without a store commit");
  lrm_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    settings_q.leakage_resilient_mode |=> settings_q.leakage_resilient_mode)
    else $error("resilient mode was cleared");
  rid_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    settings_q.random_identity_select |=> settings_q.random_identity_select)
    else $error("random identity was cleared");
  limit_nonzero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    settings_q.fail_count_limit != 16'h0000)
    else $error("fail count limit is zero");
  bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");

  auth_pass_c: cover property (@(posedge aclk) mac_req && mac_ack && mac_ok);
  cfg_commit_c: cover property (@(posedge aclk) nv_req && nv_ack && !nv_err);
  nv_fail_c: cover property (@(posedge aclk) nv_req && nv_ack && nv_err);
endmodule : tcch_top
`default_nettype wire

// ==== tb/tcch_far_model.sv ====
/* far-side model: crypto engine and settings store of the handler.
   assumes a request is held until its one-cycle ack. */
`timescale 1ns/1ps
`default_nettype none
module tcch_far_model (
  // clock and knobs
  input  wire logic       aclk,
  input  wire logic       good,
  input  wire logic       nvf,
  input  wire logic [2:0] lat,
  // crypto engine and store
  input  wire logic       mac_req,
  input  wire logic       nv_req,
  output logic            mac_ack,
  output logic            mac_ok,
  output logic            mac_err,
  output logic [127:0]    mac_tag_proof,
  output logic            nv_ack,
  output logic            nv_err
);
  logic [2:0] cnt_q;
  wire        hit = cnt_q == lat && !mac_ack && !nv_ack;
  always_ff @(posedge aclk) begin
    cnt_q   <= (mac_req | nv_req) && !hit ? cnt_q + 3'h1 : 3'h0;
    mac_ack <= mac_req & hit;
    nv_ack  <= nv_req & hit & ~mac_req;
  end
  // verdicts flip outside an ack so a stale answer never looks valid
  assign mac_ok        = mac_ack ~^ good;
  assign mac_err       = ~mac_ack;
  assign mac_tag_proof = {4{mac_ack ? 32'h5a3c_9e10 : 32'ha5c3_61ef}};
  assign nv_err        = nv_ack ~^ nvf;
endmodule : tcch_far_model
`default_nettype wire

// ==== tb/testbench.sv ====
/* bench of tcch_top: axi4-lite master, far model, reference settings.
   assumes buffer words hold frame bytes lsb first, status code in bits 23:16. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, auth_amk_active = '0, comm_full_active = '0;
  logic good = 1'b1, nvf = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, mac_req, mac_ack, mac_ok, mac_err, nv_req, nv_ack, nv_err, cmd_done;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] lat = '0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [33:0] rd_q;
  logic [127:0] mac_reader_nonce, mac_reader_proof, mac_tag_proof;
  tcch_pkg::tcch_settings_t settings, nv_wdata, exp_q = tcch_pkg::SETTINGS_RST;
  logic [7:0] fr [$];
  int miscompares = 0, samples_checked = 0;
  initial forever #12.5 aclk = ~aclk;
  tcch_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .auth_amk_active,
    .comm_full_active, .mac_req, .mac_reader_nonce, .mac_reader_proof, .mac_ack, .mac_ok,
    .mac_err, .mac_tag_proof, .nv_req, .nv_wdata, .nv_ack, .nv_err, .settings, .cmd_done);
  tcch_far_model i_far (.aclk, .good, .nvf, .lat, .mac_req, .nv_req, .mac_ack, .mac_ok,
    .mac_err, .mac_tag_proof, .nv_ack, .nv_err);
  task automatic end_of_test();
    if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  task automatic check(string what, logic [63:0] seen, logic [63:0] want);
    samples_checked++;
    if (seen !== want) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic guard(int n);
    if (n >= 200) begin
      miscompares++;
      end_of_test();
    end
  endtask : guard
  // each bus task starts on a fresh edge so no strobe is driven twice in one step
  task automatic wr(logic [11:0] a, logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    guard(n);
  endtask : wr
  task automatic rd(logic [11:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b0;
      rd_q = {s_axi_rresp, s_axi_rdata};
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    guard(n);
  endtask : rd
  task automatic run(logic [7:0] st);
    int len, n;
    len = fr.size();
    lat <= 3'($urandom_range(5));
    while (fr.size() < 36) fr.push_back(8'h00);
    for (int i = 0; i < 36; i += 4) wr(12'h040 + 12'(i), {fr[i+3], fr[i+2], fr[i+1], fr[i]});
    wr(12'h000, (32'(len) << 8) | 32'h0000_0001);
    n = 0;
    do begin
      rd(12'h004);
      n++;
    end while (rd_q[1] !== 1'b1 && n < 200);
    guard(n);
    check("result", {rd_q[23:16], settings}, {st, exp_q});
  endtask : run
  task automatic cfg(logic [7:0] opt, logic [7:0] d [$], logic [7:0] st);
    fr = {8'h5C, opt, d}; // data already deciphered by the frame layer
    run(st);
  endtask : cfg
  task automatic auth(int nb, logic [7:0] st);
    fr = {8'hAF};
    repeat (nb) fr.push_back(8'($urandom));
    run(st);
  endtask : auth
  initial begin
    logic [7:0] a, b, c, e;
    void'($urandom(32'hc5a0));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    check("reset", settings, exp_q);
    cfg(8'h00, '{8'h02}, 8'hAE);
    auth_amk_active <= 1'b1;
    comm_full_active <= 1'b1;
    cfg(8'h00, '{8'h03}, 8'h9E);
    cfg(8'h07, '{8'h02}, 8'h9E);
    cfg(8'h04, '{8'h04}, 8'h7E);
    exp_q.random_identity_select = 1'b1;
    cfg(8'h00, '{8'h02}, 8'h00);
    cfg(8'h00, '{8'h00}, 8'h00);
    exp_q.chain_write_block = 1'b1;
    cfg(8'h04, '{8'h04, 8'h00}, 8'h00);
    {a, b, c, e} = $urandom;
    a = a | 8'h01;
    exp_q.leakage_resilient_mode = 1'b1;
    exp_q.cap5 = c;
    exp_q.cap6 = e;
    cfg(8'h05, '{0, 0, 0, 0, 8'h02, 0, 0, 0, c, e}, 8'h00);
    cfg(8'h05, '{0, 0, 0, 0, 8'h00, 0, 0, 0, c, e}, 8'h00);
    exp_q.fail_count_limit = {b, a};
    exp_q.fail_count_decrement = {e, c};
    cfg(8'h0A, '{8'h01, a, b, c, e}, 8'h00);
    exp_q.fail_counter_enable = 1'b0;
    cfg(8'h0A, '{8'h00, e, c, b, a}, 8'h00);
    exp_q.hw_strong = 1'b0;
    cfg(8'h0B, '{8'h00}, 8'h00);
    nvf <= 1'b1;
    cfg(8'h0B, '{8'h01}, 8'hEE);
    nvf <= 1'b0;
    auth(31, 8'h7E);
    good <= 1'b0;
    auth(32, 8'hAE);
    good <= 1'b1;
    auth(32, 8'h00);
    for (int k = 0; k < 4; k++) begin
      rd(12'h010 + 12'(4 * k));
      check("tag_proof", rd_q[31:0], 32'h5a3c_9e10);
    end
    rd(12'h03C);
    check("rresp", rd_q[33:32], 2'h2);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
